// *** include/nvg_pkg.sv ***
// shared constants and types for the storage-mapped express output pin
package nvg_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_INDEX = 8'h04;
   localparam logic [7:0] OFF_SIZE = 8'h08;
   localparam logic [7:0] OFF_ATTR = 8'h0C;
   localparam logic [7:0] OFF_DATA = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   // command opcodes, CMD[3:0]
   localparam logic [3:0] OP_STARTUP = 4'h1;
   localparam logic [3:0] OP_DEFINE = 4'h2;
   localparam logic [3:0] OP_WRITE = 4'h3;
   localparam logic [3:0] OP_AUTH_WRITE = 4'h4;
   localparam logic [3:0] OP_READ = 4'h5;
   localparam logic [3:0] OP_AUTH_READ = 4'h6;
   localparam logic [3:0] OP_TAKE_OWNER = 4'h7;
   localparam logic [3:0] OP_OWNER_CLEAR = 4'h8;
   localparam logic [3:0] OP_POWER_CHANGE = 4'h9;
   // result codes
   localparam logic [7:0] RC_SUCCESS = 8'h00;
   localparam logic [7:0] RC_AREA_LOCKED = 8'h01;
   localparam logic [7:0] RC_BAD_INDEX = 8'h02;
   localparam logic [7:0] RC_NO_OWNER = 8'h03;
   localparam logic [7:0] RC_UNDEFINED = 8'h04;
   localparam logic [7:0] RC_AUTH_FAIL = 8'h05;
   localparam logic [7:0] RC_BAD_OPCODE = 8'h06;
   // gpio index bands, low byte of the index
   localparam logic [7:0] SLOT_EXPRESS = 8'h00;
   localparam logic [7:0] SLOT_RES_LO = 8'h01;
   localparam logic [7:0] SLOT_RES_HI = 8'h7F;
   // read and write permission attribute positions 1-2 and 16-18
   localparam logic [31:0] PERM_MASK = 32'h0007_0006;
   // status field positions
   localparam int ST_CODE_LSB = 0;
   localparam int ST_DATA_LSB = 8;
   localparam int ST_PIN_BIT = 16;
   localparam int ST_DEF_BIT = 17;
   localparam int ST_OWN_BIT = 18;
   localparam int ST_START_BIT = 19;
   localparam int ST_BUSY_BIT = 20;
   // reset values and axi response codes
   localparam logic PIN_RESET = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } nvg_wr_t;

   typedef enum logic [1:0] {
      NVG_IDLE = 2'b01,
      NVG_EXEC = 2'b10
   } nvg_state_t;
endpackage

// *** hw/nvg_axil_slave.sv ***
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module nvg_axil_slave (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // axi4-lite
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   output nvg_pkg::nvg_wr_t wr,
   output logic wr_en,
   input wire logic wr_err,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;

   assign s_axi_awready = ~aw_q & ~bvalid_q;
   assign s_axi_wready = ~w_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign wr_en = aw_q & w_q & ~bvalid_q;
   assign wr = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};
   assign rd_addr = s_axi_araddr;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= nvg_pkg::RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_err ? nvg_pkg::RESP_SLVERR : nvg_pkg::RESP_OKAY;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= nvg_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_data;
         rresp_q <= rd_err ? nvg_pkg::RESP_SLVERR : nvg_pkg::RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule

// *** hw/nvg_pin_hold.sv ***
// express pin level register with preset and read-time sampling
`timescale 1ns/1ps
module nvg_pin_hold (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // level control
   input wire logic preset,
   input wire logic load,
   input wire logic load_val,
   // read sampling
   input wire logic sense,
   input wire logic sample,
   // outputs
   output logic pin_q,
   output logic sample_q
);
   // preset wins so an undefine can never leave the pin low
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_q <= nvg_pkg::PIN_RESET;
      end else if (preset) begin
         pin_q <= 1'b1;
      end else if (load) begin
         pin_q <= load_val;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sample_q <= 1'b0;
      end else if (sample) begin
         sample_q <= sense;
      end
   end
endmodule

// *** hw/nvg_gpio_top.sv ***
// storage-index mapped express output pin with axi4-lite command port
`timescale 1ns/1ps
// Functional notes
// RULE_01: gpio slot 00 is express pin, 01-7F reserved unused, 80-FF vendor use.
// RULE_02: without the feature, defining a range covering express index returns area locked.
// RULE_03: express index undefined until defined; pin high while undefined or feature absent.
// RULE_04: any startup drives pin high; unchanged until a value write to express index.
// RULE_05: express area needs an owner; clearing the owner deallocates it.
// RULE_06: pin field is bit 0; bits 1-7 ignored on write, read as zero.
// RULE_07: writing 1 drives pin high, writing 0 drives it low.
// RULE_08: pin holds until next write, power state change, or undefinition.
// RULE_09: value read returns actual pin level sampled when the read executes.
// RULE_10: feature optional; when present it behaves completely as described here.
// RULE_11: no permission attribute bits set in 1-2, 16-18 means public access.
// RULE_12: pin register loads edge after commit; preset high on startup and undefine.
module nvg_gpio_top #(
   parameter logic [31:0] GPIO_BASE = 32'h0000_1000,
   parameter bit FEATURE_EN = 1'b1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // axi4-lite register port
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // express pin
   output logic express_pin_o,
   input wire logic express_pin_sense
);
   nvg_pkg::nvg_wr_t wr;
   logic wr_en, wr_err, rd_err;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   nvg_pkg::nvg_state_t state_q, state_d;
   logic [3:0] op_q;
   logic [31:0] index_q, size_q, attr_q, data_q, def_attr_q;
   logic [7:0] code_q, code_d;
   logic owner_q, owner_d, defined_q, defined_d, started_q, started_d;
   logic pin_preset, pin_load, pin_sample, sample_q;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   nvg_axil_slave u_bus (
      .clock(clock),
      .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr(wr),
      .wr_en(wr_en),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // write decode
   wire wr_cmd = wr_en && wr.addr == nvg_pkg::OFF_CMD;
   wire wr_index = wr_en && wr.addr == nvg_pkg::OFF_INDEX;
   wire wr_size = wr_en && wr.addr == nvg_pkg::OFF_SIZE;
   wire wr_attr = wr_en && wr.addr == nvg_pkg::OFF_ATTR;
   wire wr_data = wr_en && wr.addr == nvg_pkg::OFF_DATA;
   assign wr_err = wr_en && !(wr_cmd || wr_index || wr_size || wr_attr || wr_data);
   // a command written while one executes is dropped; software polls busy
   wire idle = state_q == nvg_pkg::NVG_IDLE;
   wire exec = state_q == nvg_pkg::NVG_EXEC;
   wire go = wr_cmd && wr.strb[0] && idle;

   // index classification; the gpio block is 256-aligned at GPIO_BASE
   wire in_gpio = index_q[31:8] == GPIO_BASE[31:8];
   wire [7:0] slot = index_q[7:0];
   wire is_express = in_gpio && slot == nvg_pkg::SLOT_EXPRESS;
   wire is_reserved = in_gpio && slot >= nvg_pkg::SLOT_RES_LO && slot <= nvg_pkg::SLOT_RES_HI;
   wire [31:0] base_gap = GPIO_BASE - index_q;
   wire covers_express = index_q <= GPIO_BASE && base_gap < size_q;
   wire plain_cmd = op_q == nvg_pkg::OP_WRITE || op_q == nvg_pkg::OP_READ;
   wire perm_set = |(def_attr_q & nvg_pkg::PERM_MASK);
   wire is_write = op_q == nvg_pkg::OP_WRITE || op_q == nvg_pkg::OP_AUTH_WRITE;
   wire is_read = op_q == nvg_pkg::OP_READ || op_q == nvg_pkg::OP_AUTH_READ;
   wire access_ok = FEATURE_EN && is_express && defined_q && !(plain_cmd && perm_set);
   wire write_ok = exec && is_write && access_ok;
   wire read_ok = exec && is_read && access_ok;
   wire def_cmd = exec && op_q == nvg_pkg::OP_DEFINE;
   wire def_ok = FEATURE_EN && is_express && owner_q;

   // a single exec cycle lets flags, code and pin all settle on one edge
   always_comb begin
      state_d = state_q;
      case (state_q)
         nvg_pkg::NVG_IDLE: begin
            if (go) begin
               state_d = nvg_pkg::NVG_EXEC;
            end
         end
         nvg_pkg::NVG_EXEC: begin
            state_d = nvg_pkg::NVG_IDLE;
         end
         default: begin
            state_d = nvg_pkg::NVG_IDLE;
         end
      endcase
   end

   // command outcome, evaluated in the single exec cycle
   always_comb begin
      code_d = code_q;
      owner_d = owner_q;
      defined_d = defined_q;
      started_d = started_q;
      pin_preset = 1'b0;
      if (exec) begin
         code_d = nvg_pkg::RC_SUCCESS;
         case (op_q)
            nvg_pkg::OP_STARTUP: begin
               started_d = 1'b1;
               // RULE_04: startup presets high
               pin_preset = 1'b1;
            end
            nvg_pkg::OP_DEFINE: begin
               if (!FEATURE_EN && covers_express) begin
                  // RULE_02: locked when absent
                  code_d = nvg_pkg::RC_AREA_LOCKED;
               end else if (!is_express) begin
                  // RULE_01: only slot 00 served
                  code_d = nvg_pkg::RC_BAD_INDEX;
               end else if (!owner_q) begin
                  // RULE_05: owner required
                  code_d = nvg_pkg::RC_NO_OWNER;
               end else if (size_q == 32'h0000_0000) begin
                  defined_d = 1'b0;
                  // RULE_08: undefinition releases pin
                  pin_preset = 1'b1;
               end else begin
                  // RULE_03: defined only here
                  defined_d = 1'b1;
               end
            end
            nvg_pkg::OP_WRITE, nvg_pkg::OP_AUTH_WRITE, nvg_pkg::OP_READ,
            nvg_pkg::OP_AUTH_READ: begin
               if (!FEATURE_EN || !defined_q) begin
                  // RULE_10: absent feature never defined
                  code_d = is_express ? nvg_pkg::RC_UNDEFINED : nvg_pkg::RC_BAD_INDEX;
               end else if (!is_express) begin
                  code_d = nvg_pkg::RC_BAD_INDEX;
               end else if (plain_cmd && perm_set) begin
                  // RULE_11: public only with no permission bits
                  code_d = nvg_pkg::RC_AUTH_FAIL;
               end
            end
            nvg_pkg::OP_TAKE_OWNER: begin
               owner_d = 1'b1;
            end
            nvg_pkg::OP_OWNER_CLEAR: begin
               owner_d = 1'b0;
               // RULE_05: deallocate on owner clear
               defined_d = 1'b0;
               pin_preset = 1'b1;
            end
            nvg_pkg::OP_POWER_CHANGE: begin
               // RULE_08: power change returns pin high
               pin_preset = 1'b1;
            end
            default: begin
               code_d = nvg_pkg::RC_BAD_OPCODE;
            end
         endcase
      end
   end

   // RULE_06: only bit 0 of the data word reaches the pin
   // RULE_07: written bit sets the level
   assign pin_load = write_ok;
   // RULE_09: sample pin at read execution
   assign pin_sample = read_ok;

   // RULE_12: level register, preset on startup and undefine
   nvg_pin_hold u_pin (
      .clock(clock),
      .rst_n(rst_n),
      .preset(pin_preset),
      .load(pin_load),
      .load_val(data_q[0]),
      .sense(express_pin_sense),
      .sample(pin_sample),
      .pin_q(express_pin_o),
      .sample_q(sample_q)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= nvg_pkg::NVG_IDLE;
         code_q <= nvg_pkg::RC_SUCCESS;
         owner_q <= 1'b0;
         defined_q <= 1'b0;
         started_q <= 1'b0;
      end else begin
         state_q <= state_d;
         code_q <= code_d;
         owner_q <= owner_d;
         defined_q <= defined_d;
         started_q <= started_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         op_q <= 4'h0;
         index_q <= 32'h0000_0000;
         size_q <= 32'h0000_0000;
         attr_q <= 32'h0000_0000;
         data_q <= 32'h0000_0000;
         def_attr_q <= 32'h0000_0000;
      end else begin
         if (go) op_q <= wr.data[3:0];
         if (wr_index) index_q <= merge(index_q, wr.data, wr.strb);
         if (wr_size) size_q <= merge(size_q, wr.data, wr.strb);
         if (wr_attr) attr_q <= merge(attr_q, wr.data, wr.strb);
         if (wr_data) data_q <= merge(data_q, wr.data, wr.strb);
         if (def_cmd && def_ok && size_q != 32'h0000_0000) def_attr_q <= attr_q;
      end
   end

   // read decode
   wire [7:0] rd_byte = {7'h00, sample_q};
   logic [31:0] status_w;
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[nvg_pkg::ST_CODE_LSB +: 8] = code_q;
      status_w[nvg_pkg::ST_DATA_LSB +: 8] = rd_byte;
      status_w[nvg_pkg::ST_PIN_BIT] = express_pin_o;
      status_w[nvg_pkg::ST_DEF_BIT] = defined_q;
      status_w[nvg_pkg::ST_OWN_BIT] = owner_q;
      status_w[nvg_pkg::ST_START_BIT] = started_q;
      status_w[nvg_pkg::ST_BUSY_BIT] = !idle;
   end
   wire rd_cmd = rd_addr == nvg_pkg::OFF_CMD;
   wire rd_index = rd_addr == nvg_pkg::OFF_INDEX;
   wire rd_size = rd_addr == nvg_pkg::OFF_SIZE;
   wire rd_attr = rd_addr == nvg_pkg::OFF_ATTR;
   wire rd_datar = rd_addr == nvg_pkg::OFF_DATA;
   wire rd_status = rd_addr == nvg_pkg::OFF_STATUS;
   assign rd_data = rd_cmd ? {28'h000_0000, op_q} :
                    rd_index ? index_q :
                    rd_size ? size_q :
                    rd_attr ? attr_q :
                    rd_datar ? data_q :
                    rd_status ? status_w : 32'h0000_0000;
   assign rd_err = !(rd_cmd || rd_index || rd_size || rd_attr || rd_datar || rd_status);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   startup_high_a: assert property ( // RULE_04
      exec && op_q == nvg_pkg::OP_STARTUP |=> express_pin_o ##1 express_pin_o)
      else $error("pin not high after startup");
   undef_high_a: assert property ( // RULE_03
      !defined_q |-> express_pin_o)
      else $error("pin low while index undefined");
   pin_write_a: assert property ( // RULE_07
      write_ok |=> express_pin_o == $past(data_q[0]) && code_q == nvg_pkg::RC_SUCCESS)
      else $error("pin does not follow written bit");
   pin_stable_a: assert property ( // RULE_08
      $changed(express_pin_o) |-> $past(exec) && $past(op_q != nvg_pkg::OP_TAKE_OWNER))
      else $error("pin changed without cause");
   gpio_locked_a: assert property ( // RULE_02
      def_cmd && !FEATURE_EN && covers_express
      |=> code_q == nvg_pkg::RC_AREA_LOCKED && !defined_q)
      else $error("absent feature allowed express define");
   reserved_band_a: assert property ( // RULE_01
      def_cmd && is_reserved |=> code_q == nvg_pkg::RC_BAD_INDEX && $stable(defined_q))
      else $error("reserved gpio slot accepted");
   owner_needed_a: assert property ( // RULE_05
      defined_q |-> owner_q)
      else $error("express area defined without owner");
   read_bits_a: assert property ( // RULE_06
      read_ok |=> status_w[15:9] == 7'h00 && status_w[8] == $past(express_pin_sense))
      else $error("read field wrong");
   read_sample_a: assert property ( // RULE_09
      read_ok ##1 !read_ok [*2] |-> sample_q == $past(express_pin_sense, 2))
      else $error("sample not held from read time");
   public_access_a: assert property ( // RULE_11
      exec && op_q == nvg_pkg::OP_WRITE && is_express && defined_q && !perm_set
      |=> code_q == nvg_pkg::RC_SUCCESS)
      else $error("public write refused");
   preset_reg_a: assert property ( // RULE_12
      exec && op_q == nvg_pkg::OP_OWNER_CLEAR |=> express_pin_o && !defined_q)
      else $error("owner clear did not release pin");
   feature_off_a: assert property ( // RULE_10
      !FEATURE_EN |-> !defined_q)
      else $error("index defined with feature absent");
   vendor_band_a: assert property ( // RULE_01
      def_cmd && in_gpio && !is_express && !is_reserved |=> code_q == nvg_pkg::RC_BAD_INDEX)
      else $error("vendor gpio slot accepted");
   power_high_a: assert property ( // RULE_08
      exec && op_q == nvg_pkg::OP_POWER_CHANGE |=> express_pin_o)
      else $error("pin not high after power change");
   no_owner_a: assert property ( // RULE_05
      def_cmd && FEATURE_EN && is_express && !owner_q
      |=> code_q == nvg_pkg::RC_NO_OWNER && !defined_q)
      else $error("define accepted without owner");

   drive_low_c: cover property (write_ok && !data_q[0] ##1 !express_pin_o);
   read_back_c: cover property (read_ok ##1 code_q == nvg_pkg::RC_SUCCESS);
   owner_clear_c: cover property (!express_pin_o ##1 exec && op_q == nvg_pkg::OP_OWNER_CLEAR);
   // reaching these shows the bench walked each lifetime step
   startup_c: cover property (exec && op_q == nvg_pkg::OP_STARTUP ##1 express_pin_o);
   undefine_c: cover property (defined_q ##1 !defined_q);
endmodule

// *** testbench/nvg_platform_model.sv ***
// platform component that senses the express pin and can pull it
`timescale 1ns/1ps
module nvg_platform_model (
   // clock
   input wire logic clock,
   // pin as driven and as seen
   input wire logic express_pin_o,
   output logic express_pin_sense,
   // outside pull, makes the real level differ from the driven one
   input wire logic ov_en,
   input wire logic ov_val
);
   // slot 00 feeds this one pin
   always_ff @(posedge clock) begin
      express_pin_sense <= ov_en ? ov_val : express_pin_o;
   end
endmodule

// *** testbench/nvg_gpio_top_bench.sv ***
// self-checking bench for the storage-mapped express pin
`timescale 1ns/1ps
module nvg_gpio_top_bench;
   localparam logic [31:0] BASE = 32'h0000_1000;
   logic clock, rst_n, ov_en, ov_val, pin_off;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_off, st, st_off, d;
   logic [3:0] s_axi_wstrb, op;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic express_pin_o, express_pin_sense, p;
   logic [31:0] band [4] = '{32'h01, 32'h7F, 32'h80, 32'hFF};
   int err_total, total_checks, seed;

   nvg_gpio_top #(.GPIO_BASE(BASE), .FEATURE_EN(1'b1)) u_dut (.*);
   // second copy without the feature, sharing the bus inputs
   nvg_gpio_top #(.GPIO_BASE(BASE), .FEATURE_EN(1'b0)) u_off (.*,
      .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_arready(), .s_axi_rdata(rd_off), .s_axi_rresp(), .s_axi_rvalid(),
      .express_pin_o(pin_off), .express_pin_sense(pin_off));
   nvg_platform_model u_plat (.*);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) check(32'h0, 32'h1);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] q);
      int n = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      q = s_axi_rdata;
      st_off = rd_off;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) check(32'h0, 32'h1);
   endtask

   // issue one command, then fetch its result code
   task automatic run(input logic [3:0] o, input logic [7:0] code);
      axw(nvg_pkg::OFF_CMD, {28'h0, o});
      axr(nvg_pkg::OFF_STATUS, st);
      check(st[7:0], code);
   endtask

   task automatic set_def(input logic [31:0] idx, input logic [31:0] sz, input logic [31:0] at);
      axw(nvg_pkg::OFF_INDEX, idx);
      axw(nvg_pkg::OFF_SIZE, sz);
      axw(nvg_pkg::OFF_ATTR, at);
   endtask

   function automatic logic [7:0] rw_code(input logic [3:0] o, input logic perm);
      if (perm && (o == nvg_pkg::OP_WRITE || o == nvg_pkg::OP_READ)) begin
         return nvg_pkg::RC_AUTH_FAIL;
      end
      return nvg_pkg::RC_SUCCESS;
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // whole sequence needs about 710 cycles
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      conclude();
   end

   initial begin
      seed = 32096;
      {err_total, total_checks} = '0;
      {rst_n, ov_en, ov_val, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      axr(nvg_pkg::OFF_STATUS, st);
      check(st[18:16], 3'h1);
      set_def(BASE, 32'h1, 32'h0);
      axw(nvg_pkg::OFF_DATA, 32'h0);
      run(nvg_pkg::OP_WRITE, nvg_pkg::RC_UNDEFINED);
      check(express_pin_o, 1'b1);
      run(nvg_pkg::OP_DEFINE, nvg_pkg::RC_NO_OWNER);
      run(nvg_pkg::OP_TAKE_OWNER, nvg_pkg::RC_SUCCESS);
      run(nvg_pkg::OP_DEFINE, nvg_pkg::RC_SUCCESS);
      check(st_off[7:0], nvg_pkg::RC_AREA_LOCKED);
      run(4'hF, nvg_pkg::RC_BAD_OPCODE);
      $display("test define done");
      repeat (8) begin
         d = $random(seed);
         op = d[8] ? nvg_pkg::OP_WRITE : nvg_pkg::OP_AUTH_WRITE;
         axw(nvg_pkg::OFF_DATA, d);
         run(op, rw_code(op, 1'b0));
         check(express_pin_o, d[0]);
         ov_en <= d[9];
         ov_val <= d[10];
         op = d[11] ? nvg_pkg::OP_READ : nvg_pkg::OP_AUTH_READ;
         run(op, nvg_pkg::RC_SUCCESS);
         check(st[15:8], {7'h0, d[9] ? d[10] : d[0]});
         check({express_pin_o, pin_off}, {d[0], 1'b1});
      end
      ov_en <= 1'b0;
      $display("test random done");
      p = express_pin_o;
      foreach (band[i]) begin
         set_def(BASE + band[i], 32'h1, 32'h0);
         run(nvg_pkg::OP_DEFINE, nvg_pkg::RC_BAD_INDEX);
         axw(nvg_pkg::OFF_DATA, {31'h0, ~p});
         run(nvg_pkg::OP_WRITE, nvg_pkg::RC_BAD_INDEX);
         check(express_pin_o, p);
      end
      set_def(BASE, 32'h1, 32'h0);
      $display("test bands done");
      for (int i = 0; i < 2; i++) begin
         axw(nvg_pkg::OFF_DATA, 32'h0);
         run(nvg_pkg::OP_WRITE, nvg_pkg::RC_SUCCESS);
         check(express_pin_o, 1'b0);
         op = i ? nvg_pkg::OP_POWER_CHANGE : nvg_pkg::OP_STARTUP;
         run(op, nvg_pkg::RC_SUCCESS);
         check(express_pin_o, 1'b1);
         run(nvg_pkg::OP_READ, nvg_pkg::RC_SUCCESS);
         check(express_pin_o, 1'b1);
      end
      $display("test startup done");
      for (int i = 0; i < 32; i++) begin
         if (nvg_pkg::PERM_MASK[i]) begin
            set_def(BASE, 32'h0, 32'h0);
            run(nvg_pkg::OP_DEFINE, nvg_pkg::RC_SUCCESS);
            check({st[17], express_pin_o}, 2'b01);
            set_def(BASE, 32'h1, 32'h1 << i);
            run(nvg_pkg::OP_DEFINE, nvg_pkg::RC_SUCCESS);
            axw(nvg_pkg::OFF_DATA, 32'h0);
            run(nvg_pkg::OP_WRITE, rw_code(nvg_pkg::OP_WRITE, 1'b1));
            check(express_pin_o, 1'b1);
            run(nvg_pkg::OP_AUTH_WRITE, rw_code(nvg_pkg::OP_AUTH_WRITE, 1'b1));
            check(express_pin_o, 1'b0);
         end
      end
      $display("test permissions done");
      run(nvg_pkg::OP_OWNER_CLEAR, nvg_pkg::RC_SUCCESS);
      check({st[18:17], express_pin_o}, 3'h1);
      run(nvg_pkg::OP_WRITE, nvg_pkg::RC_UNDEFINED);
      set_def(BASE, 32'h1, 32'h0);
      run(nvg_pkg::OP_DEFINE, nvg_pkg::RC_NO_OWNER);
      $display("test owner clear done");
      axr(8'hFC, d);
      check(d, 32'h0);
      check(resp, nvg_pkg::RESP_SLVERR);
      axw(nvg_pkg::OFF_STATUS, 32'h0);
      check(resp, nvg_pkg::RESP_SLVERR);
      s_axi_wstrb <= 4'hE;
      axw(nvg_pkg::OFF_CMD, {28'h0, nvg_pkg::OP_TAKE_OWNER});
      axr(nvg_pkg::OFF_STATUS, st);
      check(st[18], 1'b0);
      $display("test unmapped done");
      conclude();
   end
endmodule
